// File: tsstc_base_count.sv
// 33-bit base counter advanced on each extension wrap
`timescale 1ns/1ns
`include "tsstc_map.svh"
module tsstc_base_count (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic step,
    input wire logic load,
    input wire logic load_top,
    // count
    output logic [32:0] count_r
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= `TSSTC_BASE_ZERO;
        end else if (load) begin
            count_r <= {load_top, `TSSTC_WORD_ZERO};
        end else if (step) begin
            count_r <= count_r + 33'h000000001;
        end
    end
endmodule : tsstc_base_count

// File: tsstc_ext_count.sv
// extension counter that wraps after its last value
`timescale 1ns/1ns
`include "tsstc_map.svh"
module tsstc_ext_count #(
    parameter logic [8:0] LAST = `TSSTC_EXT_LAST
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic load,
    input wire logic [8:0] load_value,
    // count
    output logic [8:0] count_r,
    output logic wrap
);
    // a loaded value above the last one wraps on the next step instead of running past it
    assign wrap = run && !load && (count_r >= LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= `TSSTC_EXT_ZERO;
        end else if (load) begin
            count_r <= load_value;
        end else if (wrap) begin
            count_r <= `TSSTC_EXT_ZERO;
        end else if (run) begin
            count_r <= count_r + 9'h001;
        end
    end
endmodule : tsstc_ext_count

// File: tsstc_map.svh
// register offsets, field positions and reset values of the system time counter
`ifndef TSSTC_MAP_SVH
`define TSSTC_MAP_SVH
`define TSSTC_OFF_LOW 8'h00
`define TSSTC_OFF_HIGH 8'h04
`define TSSTC_OFF_INIT_LOW 8'h08
`define TSSTC_OFF_INIT_HIGH 8'h0C
`define TSSTC_OFF_CTRL 8'h10
`define TSSTC_CTRL_TS_MODE 0
`define TSSTC_CTRL_LOAD 1
`define TSSTC_HI_TOP_BIT 0
`define TSSTC_HI_EXT_LSB 1
`define TSSTC_HI_EXT_MSB 9
`define TSSTC_EXT_LAST 9'h12B
`define TSSTC_EXT_ZERO 9'h000
`define TSSTC_BASE_ZERO 33'h000000000
`define TSSTC_WORD_ZERO 32'h00000000
`define TSSTC_RESP_OKAY 2'h0
`define TSSTC_RESP_SLVERR 2'h2
`endif

// File: tsstc_pkg.sv
// types shared by the system time counter files
package tsstc_pkg;
    typedef struct packed {
        logic [32:0] base;
        logic [8:0] ext;
    } tsstc_time_s;
    typedef enum logic [1:0] {
        TSSTC_RD_IDLE,
        TSSTC_RD_RESP
    } tsstc_rd_e;
endpackage : tsstc_pkg

// File: tsstc_tb.sv
// self-checking bench of the system time counter
`timescale 1ns/1ns
`include "tsstc_map.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module testbench;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [1:0] resp;
    } tsstc_tb_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic tick_27mhz = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic ts_mode;
    int errors = 0;
    int checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    tsstc_tb_row_s rows [9];
    tsstc_top tsstc_top_i (.aclk(aclk), .aresetn(aresetn), .tick_27mhz(tick_27mhz),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ts_mode(ts_mode));
    initial begin
        forever #50 aclk = ~aclk;
    end
    task summarize;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task timed_out;
        errors++;
        $display("CHECK FAILED handshake expected done seen timeout");
        summarize();
    endtask : timed_out
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, haw, hw, b;
        aw = 1'b0;
        w = 1'b0;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50 && !(aw && w); i++) begin
            @(negedge aclk);
            haw = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (haw) begin s_axi_awvalid <= 1'b0; aw = 1'b1; end
            if (hw) begin s_axi_wvalid <= 1'b0; w = 1'b1; end
        end
        for (int i = 0; i < 50 && !b; i++) begin
            @(negedge aclk);
            b = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        if (!(aw && w && b)) timed_out();
    endtask : axi_write
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, h, v;
        ar = 1'b0;
        v = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50 && !ar; i++) begin
            @(negedge aclk);
            h = s_axi_arready === 1'b1;
            @(posedge aclk);
            if (h) begin s_axi_arvalid <= 1'b0; ar = 1'b1; end
        end
        for (int i = 0; i < 50 && ar && !v; i++) begin
            @(negedge aclk);
            v = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        if (!(ar && v)) timed_out();
    endtask : axi_read
    task read_time(input logic [31:0] lo, input logic [31:0] hi);
        axi_read(`TSSTC_OFF_LOW, rd, rs);
        `CHK("low word", lo, rd)
        axi_read(`TSSTC_OFF_LOW, rd, rs);
        `CHK("low word reread", lo, rd)
        axi_read(`TSSTC_OFF_HIGH, rd, rs);
        `CHK("high word", hi, rd)
    endtask : read_time
    task ticks(input int n);
        @(posedge aclk);
        tick_27mhz <= 1'b1;
        repeat (n) @(posedge aclk);
        tick_27mhz <= 1'b0;
    endtask : ticks
    initial begin
        rows[0] = {1'b1, `TSSTC_OFF_INIT_LOW, 32'hA5A55A5A, `TSSTC_RESP_OKAY};
        rows[1] = {1'b0, `TSSTC_OFF_INIT_LOW, 32'hA5A55A5A, `TSSTC_RESP_OKAY};
        rows[2] = {1'b1, `TSSTC_OFF_INIT_HIGH, 32'hFFFFFFFF, `TSSTC_RESP_OKAY};
        rows[3] = {1'b0, `TSSTC_OFF_INIT_HIGH, 32'h000003FF, `TSSTC_RESP_OKAY};
        rows[4] = {1'b1, 8'h14, 32'h12345678, `TSSTC_RESP_SLVERR};
        rows[5] = {1'b0, 8'h14, 32'h00000000, `TSSTC_RESP_SLVERR};
        rows[6] = {1'b1, `TSSTC_OFF_LOW, 32'hFFFFFFFF, `TSSTC_RESP_OKAY};
        rows[7] = {1'b0, `TSSTC_OFF_LOW, 32'h00000000, `TSSTC_RESP_OKAY};
        rows[8] = {1'b0, `TSSTC_OFF_CTRL, 32'h00000000, `TSSTC_RESP_OKAY};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("ts_mode after reset", 1'b0, ts_mode)
        read_time(32'h00000000, 32'h00000000);
        for (int i = 0; i < 9; i++) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, rs);
            end else begin
                axi_read(rows[i].addr, rd, rs);
                `CHK("row data", rows[i].data, rd)
            end
            `CHK("row resp", rows[i].resp, rs)
        end
        // idle mode: ticks must not count
        ticks(400);
        read_time(32'h00000000, 32'h00000000);
        // load strobe without transport mode is ignored
        axi_write(`TSSTC_OFF_CTRL, 32'h00000002, rs);
        `CHK("ts_mode after bare load", 1'b0, ts_mode)
        read_time(32'h00000000, 32'h00000000);
        // only byte lane 1 written: upper init bits cleared, low byte kept
        s_axi_wstrb <= 4'h2;
        axi_write(`TSSTC_OFF_INIT_HIGH, 32'h00000000, rs);
        s_axi_wstrb <= 4'hF;
        axi_read(`TSSTC_OFF_INIT_HIGH, rd, rs);
        `CHK("init high lane", 32'h000000FF, rd)
        // top bit 1, extension at its last value 299
        axi_write(`TSSTC_OFF_INIT_HIGH, 32'h00000257, rs);
        axi_write(`TSSTC_OFF_CTRL, 32'h00000003, rs);
        `CHK("ts_mode set", 1'b1, ts_mode)
        read_time(32'h00000000, 32'h00000257);
        ticks(1);
        read_time(32'h00000001, 32'h00000001);
        ticks(600);
        ticks(5);
        read_time(32'h00000003, 32'h0000000B);
        axi_write(`TSSTC_OFF_CTRL, 32'h00000000, rs);
        `CHK("ts_mode clear", 1'b0, ts_mode)
        ticks(400);
        read_time(32'h00000003, 32'h0000000B);
        // reset in mid-run
        axi_write(`TSSTC_OFF_CTRL, 32'h00000001, rs);
        ticks(350);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("ts_mode after second reset", 1'b0, ts_mode)
        read_time(32'h00000000, 32'h00000000);
        summarize();
    end
endmodule : testbench

// File: tsstc_top.sv
// system time counter of the transport stream capture interface, AXI4-Lite slave
// Behaviour
// - load base top bit from init bit 0
// - load extension from init bits 9 to 1
// - low word reads base bits 31 to 0
// - base advances at 90 kHz, read live
// - high word holds top bit and extension
// - extension advances at 27 MHz
// - top bit toggles only on base rollover, or is set from init bit 0 on load
`timescale 1ns/1ns
`include "tsstc_map.svh"
module tsstc_top (
    // clocks and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick_27mhz,
    // write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status
    output logic ts_mode
);
    logic aw_held_r;
    logic [7:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [31:0] init_low_r;
    logic [9:0] init_high_r;
    logic ts_mode_r;
    logic load_pulse;
    logic do_write;
    logic run;
    logic ext_wrap;
    logic [8:0] ext_count;
    logic [32:0] base_count;
    tsstc_pkg::tsstc_time_s now;
    tsstc_pkg::tsstc_rd_e rd_state_r;
    logic [31:0] rd_word;
    logic rd_hit;

    assign ts_mode = ts_mode_r;
    assign run = ts_mode_r && tick_27mhz;
    assign now.base = base_count;
    assign now.ext = ext_count;

    // write channels taken independently
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= `TSSTC_WORD_ZERO;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TSSTC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
                `TSSTC_OFF_LOW, `TSSTC_OFF_HIGH, `TSSTC_OFF_INIT_LOW, `TSSTC_OFF_INIT_HIGH,
                `TSSTC_OFF_CTRL: s_axi_bresp <= `TSSTC_RESP_OKAY;
                default: s_axi_bresp <= `TSSTC_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // initialisation words, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_low_r <= `TSSTC_WORD_ZERO;
            init_high_r <= 10'h000;
        end else if (do_write && aw_addr_r == `TSSTC_OFF_INIT_LOW) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb_r[i]) begin
                    init_low_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
                end
            end
        end else if (do_write && aw_addr_r == `TSSTC_OFF_INIT_HIGH) begin
            if (w_strb_r[0]) begin
                init_high_r[7:0] <= w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
                init_high_r[9:8] <= w_data_r[9:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ts_mode_r <= 1'b0;
        end else if (do_write && aw_addr_r == `TSSTC_OFF_CTRL && w_strb_r[0]) begin
            ts_mode_r <= w_data_r[`TSSTC_CTRL_TS_MODE];
        end
    end

    // load strobe: control bit 1 written as one in the same write as transport mode bit 0
    assign load_pulse = do_write && aw_addr_r == `TSSTC_OFF_CTRL && w_strb_r[0]
        && w_data_r[`TSSTC_CTRL_LOAD] && w_data_r[`TSSTC_CTRL_TS_MODE];

    tsstc_ext_count u_ext (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .load(load_pulse),
        .load_value(init_high_r[`TSSTC_HI_EXT_MSB:`TSSTC_HI_EXT_LSB]),
        .count_r(ext_count),
        .wrap(ext_wrap)
    );

    tsstc_base_count u_base (
        .aclk(aclk),
        .aresetn(aresetn),
        .step(ext_wrap),
        .load(load_pulse),
        .load_top(init_high_r[`TSSTC_HI_TOP_BIT]),
        .count_r(base_count)
    );

    // read path
    assign s_axi_arready = (rd_state_r == tsstc_pkg::TSSTC_RD_IDLE);

    always_comb begin
        rd_word = `TSSTC_WORD_ZERO;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `TSSTC_OFF_LOW: rd_word = now.base[31:0];
            `TSSTC_OFF_HIGH: rd_word = {22'h000000, now.ext, now.base[32]};
            `TSSTC_OFF_INIT_LOW: rd_word = init_low_r;
            `TSSTC_OFF_INIT_HIGH: rd_word = {22'h000000, init_high_r};
            `TSSTC_OFF_CTRL: rd_word = {31'h00000000, ts_mode_r};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= tsstc_pkg::TSSTC_RD_IDLE;
            s_axi_rdata <= `TSSTC_WORD_ZERO;
            s_axi_rresp <= `TSSTC_RESP_OKAY;
        end else begin
            unique case (rd_state_r)
                tsstc_pkg::TSSTC_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state_r <= tsstc_pkg::TSSTC_RD_RESP;
                        s_axi_rdata <= rd_word;
                        s_axi_rresp <= rd_hit ? `TSSTC_RESP_OKAY : `TSSTC_RESP_SLVERR;
                    end
                end
                tsstc_pkg::TSSTC_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_r <= tsstc_pkg::TSSTC_RD_IDLE;
                    end
                end
            endcase
        end
    end
    assign s_axi_rvalid = (rd_state_r == tsstc_pkg::TSSTC_RD_RESP);

    // checks
    AST_EXT_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
        run && !load_pulse |=> ext_count <= `TSSTC_EXT_LAST) else $error("extension out of range");
    AST_EXT_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_wrap |=> ext_count == 9'h000 && base_count == $past(base_count) + 33'h1) else $error("wrap failed");
    AST_EXT_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        run && !ext_wrap && !load_pulse |=> ext_count == $past(ext_count) + 9'h1) else $error("no step");
    AST_BASE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !ext_wrap && !load_pulse |=> $stable(base_count)) else $error("base moved");
    AST_TOP_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
        !load_pulse && base_count[31:0] != 32'hFFFFFFFF |=> $stable(base_count[32])) else $error("top bit");
    AST_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        load_pulse |=> base_count == {$past(init_high_r[0]), 32'h0} && ext_count == $past(init_high_r[9:1]))
        else $error("load value wrong");
    AST_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        !ts_mode_r && !load_pulse |=> $stable(ext_count)) else $error("counting outside mode");
    AST_RD_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `TSSTC_OFF_LOW |=> s_axi_rvalid
        && s_axi_rdata == $past(base_count[31:0])) else $error("low word read");
    AST_RD_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `TSSTC_OFF_HIGH |=> s_axi_rvalid
        && s_axi_rdata == {22'h0, $past(ext_count), $past(base_count[32])}) else $error("high word read");
    COV_WRAP: cover property (@(posedge aclk) disable iff (!aresetn) ext_wrap);
    COV_LOAD: cover property (@(posedge aclk) disable iff (!aresetn) load_pulse);
    COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
endmodule : tsstc_top
